// ### hw/ufsotg_core.v
// full-speed otg core: device link state, otg role logic and shared fifo
// Contract
// - power-off until vbus valid or ignore set
// - powered device enables dp pull-up
// - bus reset sets reset flag
// - after reset, enumeration done, speed 11
// - device mode runs full speed only
// - suspend after 3ms idle, gate clocks
// - resume while suspended sets wake flag
// - remote wake request drives wake signalling
// - soft disconnect removes dp pull-up immediately
// - sof raises flag, restarts time, frame number
// - eof1 or eof2 sets periodic frame flag
// - id pin level gives a/b role
// - role swap request runs hnp, reports success
// - current role always visible
// - vbus comparators give a and b session valid
// - session request signals, success flag set
// - a-device flags detected session request
// - one 1.25k byte sram data fifo
// - host mode three software-placed regions
// - device mode rx plus four tx regions
// - per-channel access window, rx status pop (code pops data words only, no status word)
`include "ufsotg_map.vh"
`timescale 1ns/1ps
`default_nettype none
module ufsotg_core
(
  input wire mclk,
  input wire rst,
  input wire host_mode,
  input wire vbus_valid_pin,
  input wire vbus_ignore,
  input wire a_vbus_cmp_pin,
  input wire b_vbus_cmp_pin,
  input wire sess_end_cmp_pin,
  input wire id_pin,
  input wire dp_in,
  input wire dm_in,
  input wire sof_seen,
  input wire [10:0] sof_frame,
  input wire soft_disconnect,
  input wire remote_wake_request,
  input wire port_suspend,
  input wire role_swap_request,
  input wire session_request,
  input wire flag_clear,
  input wire [7:0] flag_clear_mask,
  input wire [8:0] rx_base,
  input wire [8:0] rx_len,
  input wire [8:0] tx0_base,
  input wire [8:0] tx0_len,
  input wire [8:0] tx1_base,
  input wire [8:0] tx1_len,
  input wire [8:0] tx2_base,
  input wire [8:0] tx2_len,
  input wire [8:0] tx3_base,
  input wire [8:0] tx3_len,
  input wire push_valid,
  input wire [2:0] push_channel,
  input wire [31:0] push_data,
  output wire push_ready,
  input wire pop_req,
  input wire [2:0] pop_channel,
  output reg [31:0] pop_data_ff,
  output reg pop_valid_ff,
  output reg powered_ff,
  output wire dp_pullup,
  output reg suspended_ff,
  output wire clock_gate_en,
  output reg [1:0] enumerated_speed_ff,
  output reg [10:0] received_frame_number_ff,
  output reg [7:0] global_interrupt_flags_ff,
  output reg id_pin_level_ff,
  output reg a_session_valid_ff,
  output reg b_session_valid_ff,
  output reg role_swap_success_ff,
  output reg session_request_success_ff,
  output reg current_role_ff,
  output reg dp_drive_ff,
  output reg dm_drive_ff,
  output reg bus_oe_ff,
  output reg vbus_pulse_ff
);
  // flag bit positions inside global_interrupt_flags
  localparam F_RST = 0;
  localparam F_ENUM = 1;
  localparam F_WAKE = 2;
  localparam F_SOF = 3;
  localparam F_EOPF = 4;
  localparam F_SESS = 5;
  localparam F_SUSP = 6;
  localparam F_HNP = 7;
  // link states
  localparam ST_OFF = 3'h0;
  localparam ST_ATTACH = 3'h1;
  localparam ST_RESET = 3'h2;
  localparam ST_ACTIVE = 3'h3;
  localparam ST_SUSP = 3'h4;
  localparam ST_RWAKE = 3'h5;
  localparam ST_HNP = 3'h6;
  localparam ST_SRP = 3'h7;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  reg [7:0] meta_ff;
  reg [7:0] sync_ff;
  // first stage feeds only the second stage
  always @(posedge mclk)
  begin
    if (rst)
    begin
      meta_ff <= 8'h00;
      sync_ff <= 8'h00;
    end
    else
    begin
      meta_ff <= {id_pin, vbus_valid_pin, a_vbus_cmp_pin, b_vbus_cmp_pin, sess_end_cmp_pin, dp_in, dm_in, 1'b0};
      sync_ff <= meta_ff;
    end
  end
  wire s_id = sync_ff[7];
  wire s_vbus = sync_ff[6];
  wire s_avalid = sync_ff[5];
  wire s_bvalid = sync_ff[4];
  wire s_send = sync_ff[3];
  wire s_dp = sync_ff[2];
  wire s_dm = sync_ff[1];
  wire se0 = ~s_dp & ~s_dm;
  wire bus_k = ~s_dp & s_dm;

  // ----------------------------------------
  // link state machine and timers
  // ----------------------------------------
  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [`UFSOTG_CNT_W-1:0] idle_cnt_ff;
  reg [`UFSOTG_CNT_W-1:0] frame_cnt_ff;
  reg [`UFSOTG_CNT_W-1:0] tmr_ff;
  reg [1:0] line_ff;
  wire line_change = (line_ff != {s_dp, s_dm});
  wire vbus_ok = s_vbus | vbus_ignore;
  wire idle_done = (idle_cnt_ff >= `UFSOTG_SUSPEND_CYC);
  // the idle count belongs to the previous line state on the edge where se0 starts,
  // so a long idle j must not pass for a held se0
  wire se0_done = (idle_cnt_ff >= `UFSOTG_RESET_SE0_CYC) & ~line_change;
  // decides next state; device only unless acting as an otg role change
  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_OFF: if (vbus_ok & ~host_mode) nxt_state = ST_ATTACH;
      ST_ATTACH: if (se0 & se0_done) nxt_state = ST_RESET;
      ST_RESET: if (~se0) nxt_state = ST_ACTIVE;
      ST_ACTIVE:
      begin
        if (idle_done & ~se0) nxt_state = ST_SUSP;
        else if (se0 & se0_done) nxt_state = ST_RESET;
      end
      ST_SUSP:
      begin
        if (bus_k) nxt_state = ST_ACTIVE;
        else if (remote_wake_request) nxt_state = ST_RWAKE;
        else if (role_swap_request & s_id) nxt_state = ST_HNP;
      end
      ST_RWAKE: if (tmr_ff >= `UFSOTG_RWAKE_CYC) nxt_state = ST_ACTIVE;
      ST_HNP: if (tmr_ff >= `UFSOTG_HNP_CYC) nxt_state = ST_ACTIVE;
      ST_SRP: if (tmr_ff >= `UFSOTG_PULSE_CYC) nxt_state = ST_OFF;
      default: nxt_state = ST_OFF;
    endcase
    if (~vbus_ok & (state_ff != ST_SRP))
    begin
      if (s_id & session_request & s_send & ~host_mode)
        nxt_state = ST_SRP;
      else
        nxt_state = ST_OFF;
    end
  end

  // counters: idle time, frame time, state timer
  always @(posedge mclk)
  begin
    if (rst)
    begin
      state_ff <= ST_OFF;
      idle_cnt_ff <= `UFSOTG_CNT_ZERO;
      frame_cnt_ff <= `UFSOTG_CNT_ZERO;
      tmr_ff <= `UFSOTG_CNT_ZERO;
      line_ff <= 2'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      line_ff <= {s_dp, s_dm};
      if (line_change | sof_seen)
        idle_cnt_ff <= `UFSOTG_CNT_ZERO;
      else if (~idle_done)
        idle_cnt_ff <= idle_cnt_ff + `UFSOTG_CNT_ONE;
      if (sof_seen)
        frame_cnt_ff <= `UFSOTG_CNT_ZERO;
      else if (frame_cnt_ff < `UFSOTG_FRAME_CYC)
        frame_cnt_ff <= frame_cnt_ff + `UFSOTG_CNT_ONE;
      if (nxt_state != state_ff)
        tmr_ff <= `UFSOTG_CNT_ZERO;
      else
        tmr_ff <= tmr_ff + `UFSOTG_CNT_ONE;
    end
  end

  // ----------------------------------------
  // bus drive and status outputs
  // ----------------------------------------
  // pull-up follows power, dropped at once by soft disconnect
  assign dp_pullup = powered_ff & ~soft_disconnect & ~host_mode;
  // suspended logic stops its clocks; frame time keeps counting, only the eof flag is masked
  assign clock_gate_en = ~suspended_ff;
  reg hnp_role_ff;
  wire hnp_won = (state_ff == ST_HNP) & (nxt_state == ST_ACTIVE);
  always @(posedge mclk)
  begin
    if (rst)
    begin
      powered_ff <= 1'b0;
      suspended_ff <= 1'b0;
      dp_drive_ff <= 1'b0;
      dm_drive_ff <= 1'b0;
      bus_oe_ff <= 1'b0;
      vbus_pulse_ff <= 1'b0;
      enumerated_speed_ff <= 2'h0;
      received_frame_number_ff <= 11'h000;
      id_pin_level_ff <= 1'b0;
      a_session_valid_ff <= 1'b0;
      b_session_valid_ff <= 1'b0;
      current_role_ff <= 1'b0;
      hnp_role_ff <= 1'b0;
    end
    else
    begin
      powered_ff <= (nxt_state != ST_OFF) & (nxt_state != ST_SRP);
      suspended_ff <= (nxt_state == ST_SUSP);
      // remote wake drives a k state (dp low, dm high)
      bus_oe_ff <= (nxt_state == ST_RWAKE);
      dp_drive_ff <= 1'b0;
      dm_drive_ff <= (nxt_state == ST_RWAKE);
      vbus_pulse_ff <= (nxt_state == ST_SRP);
      enumerated_speed_ff <= `UFSOTG_SPEED_FULL;
      if (sof_seen)
        received_frame_number_ff <= sof_frame;
      id_pin_level_ff <= s_id;
      a_session_valid_ff <= s_avalid;
      b_session_valid_ff <= s_bvalid;
      // role: a-device is always host; a b-device becomes host once hnp wins
      // role is rebuilt every cycle so leaving host mode drops it again
      if (hnp_won)
        hnp_role_ff <= 1'b1;
      else if (~vbus_ok)
        hnp_role_ff <= 1'b0;
      current_role_ff <= host_mode | ~s_id | hnp_role_ff | hnp_won;
    end
  end

  // ----------------------------------------
  // sticky flags: set beats clear
  // ----------------------------------------
  reg [7:0] evt;
  reg sess_seen_ff;
  always @*
  begin
    evt = 8'h00;
    evt[F_RST] = (nxt_state == ST_RESET) & (state_ff != ST_RESET);
    evt[F_ENUM] = (state_ff == ST_RESET) & (nxt_state == ST_ACTIVE);
    evt[F_WAKE] = (state_ff == ST_SUSP) & bus_k;
    evt[F_SOF] = sof_seen;
    evt[F_EOPF] = ~suspended_ff & ((frame_cnt_ff == `UFSOTG_EOF1_CYC) | (frame_cnt_ff == `UFSOTG_EOF2_CYC));
    // a-device sees the b-device data-line pulse while vbus is down
    evt[F_SESS] = ~s_id & ~s_vbus & s_dp & ~sess_seen_ff;
    evt[F_SUSP] = (nxt_state == ST_SUSP) & (state_ff != ST_SUSP);
    evt[F_HNP] = (state_ff == ST_HNP) & (nxt_state != ST_HNP);
  end
  always @(posedge mclk)
  begin
    if (rst)
    begin
      global_interrupt_flags_ff <= 8'h00;
      sess_seen_ff <= 1'b0;
      role_swap_success_ff <= 1'b0;
      session_request_success_ff <= 1'b0;
    end
    else
    begin
      global_interrupt_flags_ff <= (global_interrupt_flags_ff & ~({8{flag_clear}} & flag_clear_mask)) | evt;
      sess_seen_ff <= ~s_id & ~s_vbus & s_dp;
      if (evt[F_HNP])
        role_swap_success_ff <= (nxt_state == ST_ACTIVE);
      else if (role_swap_request & (state_ff == ST_SUSP))
        role_swap_success_ff <= 1'b0;
      if ((state_ff == ST_SRP) & s_bvalid)
        session_request_success_ff <= 1'b1;
      else if (~session_request)
        session_request_success_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // shared data fifo, 320 words of 32 bits
  // ----------------------------------------
  // host: region 0 rx, 1 non-periodic tx, 2 periodic tx; device: 0 rx, 1..4 tx
  reg [31:0] fifo_mem [0:`UFSOTG_FIFO_WORDS-1];
  reg [8:0] wptr_ff [0:4];
  reg [8:0] rptr_ff [0:4];
  reg [9:0] fill_ff [0:4];
  // maps channel or endpoint window to region
  function [2:0] region_of;
    input hm;
    input [2:0] ch;
    begin
      if (hm)
        region_of = (ch == 3'h0) ? 3'h0 : (ch[0] ? 3'h1 : 3'h2);
      else
        region_of = (ch > 3'h4) ? `UFSOTG_REGION_NONE : ch;
    end
  endfunction
  function [8:0] base_of;
    input [2:0] r;
    begin
      case (r)
        3'h0: base_of = rx_base;
        3'h1: base_of = tx0_base;
        3'h2: base_of = tx1_base;
        3'h3: base_of = tx2_base;
        default: base_of = tx3_base;
      endcase
    end
  endfunction
  function [8:0] len_of;
    input [2:0] r;
    begin
      case (r)
        3'h0: len_of = rx_len;
        3'h1: len_of = tx0_len;
        3'h2: len_of = tx1_len;
        3'h3: len_of = tx2_len;
        default: len_of = tx3_len;
      endcase
    end
  endfunction
  wire [2:0] wreg = region_of(host_mode, push_channel);
  wire [2:0] rreg = region_of(host_mode, pop_channel);
  wire wok = (wreg != `UFSOTG_REGION_NONE) & (fill_ff[wreg] < {1'b0, len_of(wreg)});
  wire rok = (rreg != `UFSOTG_REGION_NONE) & (fill_ff[rreg] != 10'h000);
  assign push_ready = wok;
  wire do_push = push_valid & wok;
  wire do_pop = pop_req & rok;
  // per-region pointers wrap inside the software-given length
  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1)
    begin : g_region
      localparam [2:0] RG = g;
      wire wsel = do_push & (wreg == g);
      wire rsel = do_pop & (rreg == g);
      always @(posedge mclk)
      begin
        if (rst)
        begin
          wptr_ff[g] <= 9'h000;
          rptr_ff[g] <= 9'h000;
          fill_ff[g] <= 10'h000;
        end
        else
        begin
          if (wsel)
            wptr_ff[g] <= (wptr_ff[g] + 9'h001 >= len_of(RG)) ? 9'h000 : wptr_ff[g] + 9'h001;
          if (rsel)
            rptr_ff[g] <= (rptr_ff[g] + 9'h001 >= len_of(RG)) ? 9'h000 : rptr_ff[g] + 9'h001;
          fill_ff[g] <= fill_ff[g] + {9'h000, wsel} - {9'h000, rsel};
        end
      end
    end
  endgenerate
  // sram port: memory itself is not reset
  always @(posedge mclk)
  begin
    if (do_push)
      fifo_mem[base_of(wreg) + wptr_ff[wreg]] <= push_data;
  end
  always @(posedge mclk)
  begin
    if (rst)
    begin
      pop_data_ff <= 32'h0000_0000;
      pop_valid_ff <= 1'b0;
    end
    else
    begin
      pop_valid_ff <= do_pop;
      if (do_pop)
        pop_data_ff <= fifo_mem[base_of(rreg) + rptr_ff[rreg]];
    end
  end
endmodule
`default_nettype wire

// ### hw/ufsotg_map.vh
// constants for the full-speed otg core link logic
`ifndef UFSOTG_MAP_VH
`define UFSOTG_MAP_VH
// ----------------------------------------
// clock and timing
// ----------------------------------------
`define UFSOTG_CLK_MHZ 25
`define UFSOTG_SUSPEND_US 3000
`define UFSOTG_SUSPEND_CYC (`UFSOTG_SUSPEND_US * `UFSOTG_CLK_MHZ)
`define UFSOTG_RESET_SE0_US 3
`define UFSOTG_RESET_SE0_CYC (`UFSOTG_RESET_SE0_US * `UFSOTG_CLK_MHZ)
`define UFSOTG_FRAME_US 1000
`define UFSOTG_FRAME_CYC (`UFSOTG_FRAME_US * `UFSOTG_CLK_MHZ)
`define UFSOTG_EOF1_US 966
`define UFSOTG_EOF1_CYC (`UFSOTG_EOF1_US * `UFSOTG_CLK_MHZ)
`define UFSOTG_EOF2_US 998
`define UFSOTG_EOF2_CYC (`UFSOTG_EOF2_US * `UFSOTG_CLK_MHZ)
`define UFSOTG_RWAKE_US 2000
`define UFSOTG_RWAKE_CYC (`UFSOTG_RWAKE_US * `UFSOTG_CLK_MHZ)
`define UFSOTG_PULSE_US 8
`define UFSOTG_PULSE_CYC (`UFSOTG_PULSE_US * `UFSOTG_CLK_MHZ)
`define UFSOTG_HNP_US 100
`define UFSOTG_HNP_CYC (`UFSOTG_HNP_US * `UFSOTG_CLK_MHZ)
// ----------------------------------------
// field values and sizes
// ----------------------------------------
`define UFSOTG_SPEED_FULL 2'h3
`define UFSOTG_FIFO_WORDS 320
`define UFSOTG_FIFO_AW 9
`define UFSOTG_REGION_NONE 3'h7
`define UFSOTG_CNT_W 24
`define UFSOTG_CNT_ZERO 24'h00_0000
`define UFSOTG_CNT_ONE 24'h00_0001
`endif

// ### tb/ufsotg_core_assertions.sv
// concurrent checks on the ports of the full-speed otg core
`timescale 1ns/1ps
`default_nettype none
module ufsotg_core_assertions (
  input wire logic mclk,
  input wire logic rst,
  input wire logic host_mode,
  input wire logic vbus_valid_pin,
  input wire logic soft_disconnect,
  input wire logic sof_seen,
  input wire logic [10:0] sof_frame,
  input wire logic flag_clear,
  input wire logic [7:0] flag_clear_mask,
  input wire logic id_pin,
  input wire logic a_vbus_cmp_pin,
  input wire logic b_vbus_cmp_pin,
  input wire logic powered_ff,
  input wire logic dp_pullup,
  input wire logic [1:0] enumerated_speed_ff,
  input wire logic [7:0] global_interrupt_flags_ff,
  input wire logic [10:0] received_frame_number_ff,
  input wire logic suspended_ff,
  input wire logic clock_gate_en,
  input wire logic id_pin_level_ff,
  input wire logic a_session_valid_ff,
  input wire logic b_session_valid_ff
);
  default clocking ufsotg_cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // ----------------------------------------
  // connection, power and speed
  // ----------------------------------------
  // the pull-up has no register in its path, so a disconnect shows at once
  pullup_follows_a: assert property (dp_pullup == (powered_ff && !soft_disconnect && !host_mode))
    else $error("dp pull-up does not follow power and disconnect");
  // two sync flops plus the powered register: three edges at most
  power_on_a: assert property ($rose(vbus_valid_pin) && !host_mode |-> ##[1:4] powered_ff)
    else $error("powered state not entered after vbus rise");
  speed_full_a: assert property (!$past(rst) |-> enumerated_speed_ff == 2'h3)
    else $error("enumerated speed is not full speed");
  // ----------------------------------------
  // flags, frames and suspend
  // ----------------------------------------
  sof_frame_a: assert property (sof_seen && powered_ff |=>
    global_interrupt_flags_ff[3] && received_frame_number_ff == $past(sof_frame))
    else $error("sof flag or frame number missing");
  reset_flag_sticky_a: assert property (global_interrupt_flags_ff[0] && !(flag_clear && flag_clear_mask[0])
    |=> global_interrupt_flags_ff[0])
    else $error("bus reset flag lost without a clear");
  gate_in_suspend_a: assert property (clock_gate_en == !suspended_ff)
    else $error("clock gate does not track suspend");
  // ----------------------------------------
  // otg role and session sensing
  // ----------------------------------------
  id_level_a: assert property ($stable(id_pin) [*4] |-> id_pin_level_ff == id_pin)
    else $error("id status does not follow the id pin");
  session_valid_a: assert property (($stable(a_vbus_cmp_pin) && $stable(b_vbus_cmp_pin)) [*4] |->
    a_session_valid_ff == a_vbus_cmp_pin && b_session_valid_ff == b_vbus_cmp_pin)
    else $error("session valid bits do not follow comparators");
endmodule
bind ufsotg_core ufsotg_core_assertions ufsotg_chk (.mclk, .rst, .host_mode, .vbus_valid_pin, .soft_disconnect,
  .sof_seen, .sof_frame, .flag_clear, .flag_clear_mask, .id_pin, .a_vbus_cmp_pin, .b_vbus_cmp_pin, .powered_ff,
  .dp_pullup, .enumerated_speed_ff, .global_interrupt_flags_ff, .received_frame_number_ff, .suspended_ff,
  .clock_gate_en, .id_pin_level_ff, .a_session_valid_ff, .b_session_valid_ff);
`default_nettype wire

// ### tb/ufsotg_core_tb_top.sv
// self-checking bench for the full-speed otg core
`timescale 1ns/1ps
`default_nettype none
module ufsotg_core_tb_top;
  typedef struct packed {logic [2:0] ch; logic [31:0] din; logic [31:0] exp;} ufsotg_row_t;
  logic mclk, rst, host_mode, vbus_valid_pin, vbus_ignore, a_vbus_cmp_pin, b_vbus_cmp_pin, sess_end_cmp_pin;
  logic id_pin, sof_seen, soft_disconnect, remote_wake_request, port_suspend, role_swap_request;
  logic session_request, flag_clear, push_valid, pop_req, push_ready, pop_valid_ff, powered_ff, dp_pullup;
  logic suspended_ff, clock_gate_en, id_pin_level_ff, a_session_valid_ff, b_session_valid_ff, dp_in, dm_in;
  logic role_swap_success_ff, session_request_success_ff, current_role_ff, dp_drive_ff, dm_drive_ff;
  logic bus_oe_ff, vbus_pulse_ff;
  logic [1:0] host_line, enumerated_speed_ff;
  logic [2:0] push_channel, pop_channel;
  logic [7:0] flag_clear_mask, global_interrupt_flags_ff;
  logic [8:0] rx_base, rx_len, tx0_base, tx0_len, tx1_base, tx1_len, tx2_base, tx2_len, tx3_base, tx3_len;
  logic [10:0] sof_frame, received_frame_number_ff;
  logic [31:0] push_data, pop_data_ff;
  ufsotg_row_t rows [10];
  int failures = 0;
  int n_tests = 0;
  int i;
  ufsotg_core uut (.*);
  ufsotg_host_model far_host (.host_line, .dp_pullup, .bus_oe(bus_oe_ff), .dp_drive(dp_drive_ff),
    .dm_drive(dm_drive_ff), .dp_in, .dm_in);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task chk1(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s exp %b got %b", nm, e, g);
    end
  endtask
  task chkw(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  function automatic logic sig(input int k);
    case (k)
      8: sig = powered_ff;
      9: sig = suspended_ff;
      10: sig = bus_oe_ff;
      11: sig = vbus_pulse_ff;
      12: sig = session_request_success_ff;
      13: sig = role_swap_success_ff;
      default: sig = global_interrupt_flags_ff[k[2:0]];
    endcase
  endfunction
  // bounded wait: a hang shows up as one mismatch, not a stuck run
  task wait_sig(input int k, input int lim, input string nm);
    int n;
    n = 0;
    while (sig(k) !== 1'b1 && n < lim)
    begin
      @(negedge mclk);
      n++;
    end
    chk1(nm, 1'b1, sig(k));
  endtask
  task push(input logic [2:0] c, input logic [31:0] d, input logic ok);
    @(negedge mclk);
    push_valid = 1'b1;
    push_channel = c;
    push_data = d;
    #1 chk1("push_ready", ok, push_ready);
    @(negedge mclk);
    push_valid = 1'b0;
  endtask
  task pop(input logic [2:0] c, input logic v, input logic [31:0] d);
    @(negedge mclk);
    pop_req = 1'b1;
    pop_channel = c;
    @(negedge mclk);
    pop_req = 1'b0;
    chk1("pop_valid", v, pop_valid_ff);
    if (v)
      chkw("pop_data", d, pop_data_ff);
  endtask
  task clr;
    @(negedge mclk);
    flag_clear = 1'b1;
    flag_clear_mask = 8'hff;
    @(negedge mclk);
    flag_clear = 1'b0;
  endtask
  task complete_run;
    if (failures == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ----------------------------------------
  // clock, watchdog and sequence
  // ----------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // the suspend idle span dominates the run, so the limit sits about half as much again past it
  initial
  begin
    repeat (112000) @(posedge mclk);
    failures++;
    complete_run;
  end
  initial
  begin
    {host_mode, vbus_valid_pin, vbus_ignore, a_vbus_cmp_pin, b_vbus_cmp_pin, sess_end_cmp_pin, sof_seen} = '0;
    {soft_disconnect, remote_wake_request, port_suspend, role_swap_request, session_request} = '0;
    {flag_clear, push_valid, pop_req, push_channel, pop_channel, push_data, sof_frame, flag_clear_mask} = '0;
    {rst, id_pin, host_line} = {1'b1, 1'b1, 2'd3};
    {rx_base, rx_len, tx0_base, tx0_len, tx1_base, tx1_len} = {9'h000, 9'h004, 9'h004, 9'h004, 9'h008, 9'h004};
    {tx2_base, tx2_len, tx3_base, tx3_len} = {9'h00c, 9'h004, 9'h010, 9'h004};
    for (i = 0; i < 10; i++)
      rows[i] = '{3'(i % 5), 32'h5a00_0000 + 32'(i), 32'h5a00_0000 + 32'(i)};
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    repeat (6) @(negedge mclk);
    chk1("powered", 1'b0, powered_ff);
    chkw("speed", 32'h0000_0003, {30'h0, enumerated_speed_ff});
    vbus_ignore = 1'b1;
    wait_sig(8, 6, "powered");
    chk1("pullup", 1'b1, dp_pullup);
    // keep the ignore bit until the synced vbus level has caught up
    vbus_valid_pin = 1'b1;
    repeat (3) @(negedge mclk);
    vbus_ignore = 1'b0;
    repeat (6) @(negedge mclk);
    chk1("powered", 1'b1, powered_ff);
    soft_disconnect = 1'b1;
    #1 chk1("pullup", 1'b0, dp_pullup);
    @(negedge mclk);
    soft_disconnect = 1'b0;
    host_line = 2'd1;
    repeat (70) @(negedge mclk);
    chk1("bus_reset", 1'b0, global_interrupt_flags_ff[0]);
    wait_sig(0, 15, "bus_reset");
    host_line = 2'd0;
    wait_sig(1, 10, "enum_done");
    clr;
    @(negedge mclk);
    {sof_seen, sof_frame} = {1'b1, 11'h7ff};
    @(negedge mclk);
    sof_seen = 1'b0;
    chk1("sof", 1'b1, global_interrupt_flags_ff[3]);
    chkw("frame", 32'h0000_07ff, {21'h0, received_frame_number_ff});
    repeat (24100) @(negedge mclk);
    chk1("eopf", 1'b0, global_interrupt_flags_ff[4]);
    wait_sig(4, 100, "eopf");
    // every endpoint region holds its own words in order
    for (i = 0; i < 10; i++)
      push(rows[i].ch, rows[i].din, 1'b1);
    for (i = 0; i < 10; i++)
      pop(rows[i].ch, 1'b1, rows[i].exp);
    for (i = 0; i < 5; i++)
      push(3'd0, 32'hc0de_0000 + 32'(i), i < 4);
    push(3'd5, 32'hdead_0005, 1'b0);
    for (i = 0; i < 4; i++)
      pop(3'd0, 1'b1, 32'hc0de_0000 + 32'(i));
    pop(3'd0, 1'b0, 32'h0000_0000);
    host_mode = 1'b1;
    push(3'd1, 32'h0a0a_0001, 1'b1);
    push(3'd3, 32'h0b0b_0003, 1'b1);
    push(3'd2, 32'h0c0c_0002, 1'b1);
    pop(3'd3, 1'b1, 32'h0a0a_0001);
    pop(3'd1, 1'b1, 32'h0b0b_0003);
    pop(3'd4, 1'b1, 32'h0c0c_0002);
    pop(3'd2, 1'b0, 32'h0000_0000);
    host_mode = 1'b0;
    {a_vbus_cmp_pin, port_suspend} = 2'b11;
    clr;
    wait_sig(9, 76000, "suspended");
    chk1("susp_flag", 1'b1, global_interrupt_flags_ff[6]);
    chk1("clk_gate", 1'b0, clock_gate_en);
    chk1("role_dev", 1'b0, current_role_ff);
    role_swap_request = 1'b1;
    wait_sig(13, 3000, "hnp_ok");
    chk1("role_host", 1'b1, current_role_ff);
    role_swap_request = 1'b0;
    wait_sig(9, 8, "resuspend");
    remote_wake_request = 1'b1;
    wait_sig(10, 8, "wake_oe");
    chk1("wake_k", 1'b1, dm_drive_ff & ~dp_drive_ff);
    {remote_wake_request, port_suspend} = 2'b00;
    {b_vbus_cmp_pin, vbus_valid_pin, sess_end_cmp_pin, session_request} = 4'b1011;
    wait_sig(11, 10, "srp_pulse");
    wait_sig(12, 400, "srp_ok");
    {session_request, id_pin, host_line} = {1'b0, 1'b0, 2'd1};
    repeat (6) @(negedge mclk);
    host_line = 2'd0;
    wait_sig(5, 10, "sess_det");
    rst = 1'b1;
    repeat (16) @(negedge mclk);
    chk1("rst_power", 1'b0, powered_ff);
    chkw("rst_flags", 32'h0000_0000, {24'h0, global_interrupt_flags_ff});
    chk1("rst_oe", 1'b0, bus_oe_ff);
    complete_run;
  end
endmodule
`default_nettype wire

// ### tb/ufsotg_host_model.sv
// behavioural usb partner on the far side of the core's data lines
`timescale 1ns/1ps
`default_nettype none
module ufsotg_host_model (
  input wire logic [1:0] host_line,
  input wire logic dp_pullup,
  input wire logic bus_oe,
  input wire logic dp_drive,
  input wire logic dm_drive,
  output logic dp_in,
  output logic dm_in
);
  // ----------------------------------------
  // line resolution
  // ----------------------------------------
  // codes: 0 idle j, 1 se0, 2 k, 3 released; the core wins while it drives
  always_comb
  begin
    if (bus_oe)
    begin
      dp_in = dp_drive;
      dm_in = dm_drive;
    end
    else if (host_line == 2'd1)
    begin
      dp_in = 1'b0;
      dm_in = 1'b0;
    end
    else if (host_line == 2'd2)
    begin
      dp_in = 1'b0;
      dm_in = 1'b1;
    end
    else if (host_line == 2'd0)
    begin
      dp_in = 1'b1;
      dm_in = 1'b0;
    end
    else
    begin
      dp_in = dp_pullup;
      dm_in = 1'b0;
    end
  end
endmodule
`default_nettype wire
